// ==== hw/timer_capture_unit.sv ====
// How it works
// - a qualifying pin event copies the 16-bit timer into the result pair.
// - mode field picks falling, rising, every 4th or every 16th rising edge.
// - every capture sets the capture event flag.
// - hardware never clears the flag; software writes one to clear it.
// - a new capture overwrites an unread result.
// - pin level is sensed even when the pin is driven as an output.
// - mode changes may raise a false flag; software clears it afterwards.
// - prescaler clears while the unit is off or not capturing.
// - any reset clears the prescaler.
// - switching prescale settings directly keeps the prescaler count.
// - on instruction clock the timer holds during sleep and resumes.
// - on external clock, capture keeps working during sleep.
// - two independent capture units, each with its own registers and pin.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_unit
   import capture_pkg::*;
#(
   parameter int UNITS = 2
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic [UNITS-1:0] i_capture_pin,
   output logic [UNITS-1:0] o_capture_pin,
   output logic [UNITS-1:0] o_capture_pin_oe,
   input wire logic i_ext_clock,
   input wire logic i_sleep,
   output logic [UNITS-1:0] o_capture_event_flag
);

   // unit blocks must fit the 8-bit address map
   if (UNITS < 1 || UNITS > 4) begin : g_bad_units
      $error("UNITS must lie between 1 and 4");
   end

   // address of one per-unit register
   function automatic logic unit_hit(input logic [7:0] a,
                                     input int u,
                                     input logic [7:0] ofs);
      logic [7:0] base;
      base = 8'(OFS_UNIT_BASE + 8'(u) * OFS_UNIT_STRIDE);
      return a == 8'(base + ofs);
   endfunction

   // mode codes that count as capture operation
   function automatic logic is_cap(input logic [3:0] m);
      return m == MODE_FALL || m == MODE_RISE ||
             m == MODE_RISE4 || m == MODE_RISE16;
   endfunction

   bus_req_t req;
   logic wr_ok;
   logic [31:0] next_readdata;
   logic [15:0] tcount;
   logic [1:0] tctrl;
   logic [1:0] div;
   logic ext_q;
   logic ext_rise;
   logic timer_tick;
   logic [3:0] mode [UNITS];
   unit_t unit [UNITS];
   logic [UNITS-1:0] pin_meta;
   logic [UNITS-1:0] pin_sync;
   logic [UNITS-1:0] sense_q;
   logic [UNITS-1:0] sense;
   logic [UNITS-1:0] rise;
   logic [UNITS-1:0] fall;
   logic [UNITS-1:0] fire;

   // bus request bundle; write lands only on the accept edge
   always_comb begin
      req.rd = i_read;
      req.wr = i_write;
      req.addr = i_address;
      req.wdata = i_writedata[7:0];
   end
   assign wr_ok = req.wr && !o_waitrequest && i_byteenable[0];

   // one wait cycle per access, answer in the next
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_waitrequest <= 1'b1;
         o_readdata <= UNMAPPED_READ;
      end else if (i_clk_en) begin
         o_waitrequest <= !((req.rd || req.wr) && o_waitrequest);
         if (req.rd && o_waitrequest) begin
            o_readdata <= next_readdata;
         end
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      next_readdata = UNMAPPED_READ;
      unique case (req.addr)
         OFS_TIMER_CTRL: next_readdata[1:0] = tctrl;
         OFS_TIMER_LOW: next_readdata[7:0] = tcount[7:0];
         OFS_TIMER_HIGH: next_readdata[7:0] = tcount[15:8];
         OFS_FLAG: next_readdata[UNITS-1:0] = o_capture_event_flag;
         OFS_DIR: next_readdata[UNITS-1:0] = ~o_capture_pin_oe;
         OFS_LATCH: next_readdata[UNITS-1:0] = o_capture_pin;
         default: begin
            for (int u = 0; u < UNITS; u++) begin
               if (unit_hit(req.addr, u, OFS_UNIT_CTRL)) begin
                  next_readdata[3:0] = mode[u];
               end
               if (unit_hit(req.addr, u, OFS_UNIT_LOW)) begin
                  next_readdata[7:0] = unit[u].result[7:0];
               end
               if (unit_hit(req.addr, u, OFS_UNIT_HIGH)) begin
                  next_readdata[7:0] = unit[u].result[15:8];
               end
            end
         end
      endcase
   end

   // software control: timer setup, pin direction and latch, modes
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tctrl <= TCTRL_RESET;
         o_capture_pin_oe <= '0;
         o_capture_pin <= '0;
         for (int u = 0; u < UNITS; u++) begin
            mode[u] <= MODE_OFF;
         end
      end else if (i_clk_en && wr_ok) begin
         if (req.addr == OFS_TIMER_CTRL) begin
            tctrl <= req.wdata[1:0];
         end
         if (req.addr == OFS_DIR) begin
            o_capture_pin_oe <= ~req.wdata[UNITS-1:0];
         end
         if (req.addr == OFS_LATCH) begin
            o_capture_pin <= req.wdata[UNITS-1:0];
         end
         for (int u = 0; u < UNITS; u++) begin
            if (unit_hit(req.addr, u, OFS_UNIT_CTRL)) begin
               mode[u] <= req.wdata[3:0];
            end
         end
      end
   end

   // timer tick: external edges, or instruction clock gated by sleep
   assign ext_rise = i_ext_clock && !ext_q;
   assign timer_tick = tctrl[TCTRL_EN_BIT] &&
      (tctrl[TCTRL_EXT_BIT] ? ext_rise :
       (div == INSTR_DIV_LAST && !i_sleep));

   // sixteen-bit timer; only synchronized counting exists here
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         tcount <= TIMER_RESET;
         div <= '0;
         ext_q <= 1'b0;
      end else if (i_clk_en) begin
         ext_q <= i_ext_clock;
         div <= 2'(div + 2'h1);
         if (wr_ok && req.addr == OFS_TIMER_LOW) begin
            tcount[7:0] <= req.wdata;
         end else if (wr_ok && req.addr == OFS_TIMER_HIGH) begin
            tcount[15:8] <= req.wdata;
         end else if (timer_tick) begin
            tcount <= 16'(tcount + 16'h0001);
         end
      end
   end

   // pin synchroniser; the first stage feeds the second only
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
         sense_q <= '0;
      end else if (i_clk_en) begin
         pin_meta <= i_capture_pin;
         pin_sync <= pin_meta;
         sense_q <= sense;
      end
   end

   // a driven pin is sensed at its own latch, so port writes trigger
   assign sense = (o_capture_pin_oe & o_capture_pin) |
                  (~o_capture_pin_oe & pin_sync);
   assign rise = sense & ~sense_q;
   assign fall = ~sense & sense_q;

   // event qualification per unit
   always_comb begin
      fire = '0;
      for (int u = 0; u < UNITS; u++) begin
         unique case (mode[u])
            MODE_FALL: fire[u] = fall[u];
            MODE_RISE: fire[u] = rise[u];
            MODE_RISE4: fire[u] = rise[u] &&
               unit[u].presc == PRESC_LAST4;
            MODE_RISE16: fire[u] = rise[u] &&
               unit[u].presc == PRESC_LAST16;
            default: fire[u] = 1'b0;
         endcase
      end
   end

   // prescaler and result; switching 4 and 16 keeps the count
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         for (int u = 0; u < UNITS; u++) begin
            unit[u] <= '0;
         end
      end else if (i_clk_en) begin
         for (int u = 0; u < UNITS; u++) begin
            if (!is_cap(mode[u])) begin
               unit[u].presc <= '0;
            end else if (rise[u] && (mode[u] == MODE_RISE4 ||
                                     mode[u] == MODE_RISE16)) begin
               unit[u].presc <= fire[u] ? 4'h0 :
                  4'(unit[u].presc + 4'h1);
            end
            if (fire[u]) begin
               unit[u].result <= tcount;
            end
         end
      end
   end

   // sticky flags; a capture in the clearing cycle wins
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_capture_event_flag <= '0;
      end else if (i_clk_en) begin
         if (wr_ok && req.addr == OFS_FLAG) begin
            o_capture_event_flag <= (o_capture_event_flag &
               ~req.wdata[UNITS-1:0]) | fire;
         end else begin
            o_capture_event_flag <= o_capture_event_flag | fire;
         end
      end
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   property p_result_copy;
      i_clk_en && fire[0] |=> unit[0].result == $past(tcount);
   endproperty
   a_result_copy: assert property (p_result_copy)
      else $error("result does not hold the timer of capture cycle");

   property p_flag_set;
      i_clk_en && fire[0] |=> o_capture_event_flag[0];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("capture did not set its flag");

   property p_flag_sticky;
      o_capture_event_flag[0] && !(wr_ok && req.addr == OFS_FLAG)
      |=> o_capture_event_flag[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("flag dropped without a software clear");

   property p_presc_off;
      i_clk_en && !is_cap(mode[0]) |=> unit[0].presc == 4'h0;
   endproperty
   a_presc_off: assert property (p_presc_off)
      else $error("prescaler kept a count while not capturing");

   property p_presc_reset;
      @(posedge i_clock) disable iff (1'b0)
      !i_rst_n |=> unit[0].presc == 4'h0 && !o_capture_event_flag[0];
   endproperty
   a_presc_reset: assert property (p_presc_reset)
      else $error("reset left prescaler or flag set");

   // each rising edge steps the count; the terminal one wraps it to zero
   property p_every_fourth;
      i_clk_en && mode[0] == MODE_RISE4 && rise[0] |=>
         unit[0].presc == (($past(unit[0].presc) == PRESC_LAST4) ? 4'h0 :
                           4'($past(unit[0].presc) + 4'h1));
   endproperty
   a_every_fourth: assert property (p_every_fourth)
      else $error("divide-by-4 prescaler stepped wrongly");

   property p_fall_mode;
      i_clk_en && mode[0] == MODE_FALL && fall[0] |=>
         o_capture_event_flag[0] && unit[0].result == $past(tcount);
   endproperty
   a_fall_mode: assert property (p_fall_mode)
      else $error("falling edge missed in falling mode");

   property p_sleep_hold;
      i_clk_en && i_sleep && !tctrl[TCTRL_EXT_BIT] && !wr_ok
      |=> tcount == $past(tcount);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)
      else $error("timer moved in sleep on instruction clock");

   property p_sleep_ext;
      i_clk_en && i_sleep && tctrl == 2'h3 && ext_rise && !wr_ok
      |=> tcount == 16'($past(tcount) + 16'h0001);
   endproperty
   a_sleep_ext: assert property (p_sleep_ext)
      else $error("external timer stalled in sleep");

   // every driven unit must see its own latch one cycle later
   property p_driven_sense;
      i_clk_en |=> (sense_q & $past(o_capture_pin_oe)) ==
         ($past(o_capture_pin) & $past(o_capture_pin_oe));
   endproperty
   a_driven_sense: assert property (p_driven_sense)
      else $error("driven pin level not sensed");

   c_rise16: cover property (fire[0] && mode[0] == MODE_RISE16);
   c_clear_race: cover property (wr_ok && req.addr == OFS_FLAG && fire[0]);
   c_sleep_cap: cover property (i_sleep && fire[0] && tctrl == 2'h3);
endmodule // timer_capture_unit
`default_nettype wire

// ==== hw/capture_pkg.sv ====
package capture_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
   localparam logic [7:0] OFS_TIMER_LOW = 8'h04;
   localparam logic [7:0] OFS_TIMER_HIGH = 8'h08;
   localparam logic [7:0] OFS_FLAG = 8'h0c;
   localparam logic [7:0] OFS_DIR = 8'h10;
   localparam logic [7:0] OFS_LATCH = 8'h14;
   localparam logic [7:0] OFS_UNIT_BASE = 8'h20;
   localparam logic [7:0] OFS_UNIT_STRIDE = 8'h10;
   localparam logic [7:0] OFS_UNIT_CTRL = 8'h00;
   localparam logic [7:0] OFS_UNIT_LOW = 8'h04;
   localparam logic [7:0] OFS_UNIT_HIGH = 8'h08;
   // timer control bit positions
   localparam int unsigned TCTRL_EN_BIT = 0;
   localparam int unsigned TCTRL_EXT_BIT = 1;
   // capture mode field codes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_FALL = 4'h4;
   localparam logic [3:0] MODE_RISE = 4'h5;
   localparam logic [3:0] MODE_RISE4 = 4'h6;
   localparam logic [3:0] MODE_RISE16 = 4'h7;
   // prescaler terminal counts, instruction clock divide
   localparam logic [3:0] PRESC_LAST4 = 4'h3;
   localparam logic [3:0] PRESC_LAST16 = 4'hf;
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   localparam logic [15:0] TIMER_RESET = 16'h0000;
   localparam logic [1:0] TCTRL_RESET = 2'h0;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bus_req_t;
   typedef struct packed {
      logic [3:0] presc;
      logic [15:0] result;
   } unit_t;
endpackage

// ==== sim/capture_source.sv ====
`timescale 1ns/1ps
`default_nettype none
// far side: drives the capture pins and the external timer clock
module capture_source (
   input wire logic i_clock,
   output logic [1:0] o_pins,
   output logic o_ext
);
   initial begin
      o_pins = 2'h0;
      o_ext = 1'b0;
   end
   // hold each level six cycles so the two-flop synchroniser sees it
   task level(input int u, input logic v);
      @(posedge i_clock) o_pins[u] <= v;
      repeat (6) @(posedge i_clock);
   endtask
   task pulse(input int u);
      level(u, 1'b1);
      level(u, 1'b0);
   endtask
   // slow edges only: a sampled, synchronised count is all we promise
   task ticks(input int n);
      repeat (n) begin
         @(posedge i_clock) o_ext <= 1'b1;
         repeat (3) @(posedge i_clock);
         o_ext <= 1'b0;
         repeat (3) @(posedge i_clock);
      end
   endtask
endmodule // capture_source
`default_nettype wire

// ==== sim/timer_capture_unit_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer_capture_unit_bench;
   import capture_pkg::*;
   logic i_clock;
   logic i_rst_n;
   logic i_clk_en;
   logic [7:0] i_address;
   logic i_read;
   logic i_write;
   logic [31:0] i_writedata;
   logic [3:0] i_byteenable;
   logic i_sleep;
   logic [31:0] o_readdata;
   logic o_waitrequest, ext;
   logic [1:0] pins, pin_out, pin_oe, flags;
   int failures;
   int compares;
   always #12.5 i_clock = ~i_clock;
   timer_capture_unit #(.UNITS(2)) i_timer_capture_unit (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
      .i_address(i_address), .i_read(i_read), .i_write(i_write),
      .i_writedata(i_writedata), .i_byteenable(i_byteenable),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_capture_pin(pins), .o_capture_pin(pin_out),
      .o_capture_pin_oe(pin_oe), .i_ext_clock(ext), .i_sleep(i_sleep),
      .o_capture_event_flag(flags));
   capture_source i_src (.i_clock(i_clock), .o_pins(pins), .o_ext(ext));
   task automatic wrap_up();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one access; held until waitrequest is sampled low, bounded wait
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_clock);
      i_address <= a;
      i_write <= w;
      i_read <= !w;
      i_writedata <= d;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 20);
      q = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
      if (o_waitrequest !== 1'b0) begin
         failures++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, {24'h0, d}, q);
   endtask
   task automatic rdc(input string what, input logic [7:0] a,
         input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(what, exp, q);
   endtask
   function automatic logic [7:0] ua(input int u, input logic [7:0] o);
      return 8'(OFS_UNIT_BASE + OFS_UNIT_STRIDE * u + o);
   endfunction
   task automatic fchk(input logic [1:0] exp);
      @(posedge i_clock);
      chk("flags", {30'h0, exp}, {30'h0, flags});
   endtask
   task automatic set_timer(input logic [15:0] v);
      wr(OFS_TIMER_LOW, v[7:0]);
      wr(OFS_TIMER_HIGH, v[15:8]);
   endtask
   task automatic res(input int u, input logic [15:0] v);
      rdc("result low", ua(u, OFS_UNIT_LOW), {24'h0, v[7:0]});
      rdc("result high", ua(u, OFS_UNIT_HIGH), {24'h0, v[15:8]});
   endtask
   // off first, then the new mode, then drop any false flag
   task automatic prep(input int u, input logic [3:0] m,
         input logic [15:0] tv);
      wr(ua(u, OFS_UNIT_CTRL), 8'h00);
      set_timer(tv);
      wr(ua(u, OFS_UNIT_CTRL), {4'h0, m});
      wr(OFS_FLAG, 8'h03);
   endtask
   task automatic t_reset();
      rdc("direction", OFS_DIR, 32'h3);
      rdc("flag reg", OFS_FLAG, 32'h0);
      rdc("mode", ua(1, OFS_UNIT_CTRL), 32'h0);
      rdc("unmapped", 8'hfc, UNMAPPED_READ);
      chk("pin oe", 32'h0, {30'h0, pin_oe});
      // byte lane zero off: the write must be dropped
      @(posedge i_clock) i_byteenable <= 4'h0;
      wr(OFS_DIR, 8'h00);
      @(posedge i_clock) i_byteenable <= 4'hf;
      rdc("direction kept", OFS_DIR, 32'h3);
      wr(ua(0, OFS_UNIT_LOW), 8'h55);
      rdc("result read only", ua(0, OFS_UNIT_LOW), 32'h0);
   endtask
   task automatic t_modes();
      logic [3:0] m [4] = '{MODE_FALL, MODE_RISE, MODE_RISE4, MODE_RISE16};
      int need [4] = '{1, 1, 4, 16};
      logic [15:0] tv;
      for (int u = 0; u < 2; u++) begin
         for (int k = 0; k < 4; k++) begin
            tv = 16'h1234 + 16'(k * 273) + 16'(u * 8192);
            prep(u, m[k], tv);
            repeat (need[k] - 1) i_src.pulse(u);
            fchk(2'h0);
            i_src.level(u, 1'b1);
            fchk((k == 0) ? 2'h0 : 2'(1 << u));
            i_src.level(u, 1'b0);
            fchk(2'(1 << u));
            res(u, tv);
         end
      end
   endtask
   task automatic t_overwrite();
      prep(0, MODE_RISE, 16'h0a0b);
      i_src.pulse(0);
      set_timer(16'hc0de);
      i_src.pulse(0);
      res(0, 16'hc0de);
      repeat (40) @(posedge i_clock);
      fchk(2'h1);
      wr(OFS_FLAG, 8'h01);
      fchk(2'h0);
   endtask
   task automatic t_out_pin();
      prep(1, MODE_RISE, 16'h0777);
      wr(OFS_DIR, 8'h01);
      @(posedge i_clock);
      chk("pin oe", 32'h2, {30'h0, pin_oe});
      wr(OFS_LATCH, 8'h02);
      repeat (6) @(posedge i_clock);
      chk("pin latch", 32'h2, {30'h0, pin_out});
      fchk(2'h2);
      res(1, 16'h0777);
      wr(OFS_LATCH, 8'h00);
      wr(OFS_DIR, 8'h03);
   endtask
   task automatic t_presc();
      prep(0, MODE_RISE4, 16'h4444);
      repeat (3) i_src.pulse(0);
      wr(ua(0, OFS_UNIT_CTRL), 8'h00);
      wr(ua(0, OFS_UNIT_CTRL), {4'h0, MODE_RISE4});
      repeat (3) i_src.pulse(0);
      fchk(2'h0);
      i_src.pulse(0);
      fchk(2'h1);
      prep(0, MODE_RISE4, 16'h4545);
      repeat (2) i_src.pulse(0);
      wr(ua(0, OFS_UNIT_CTRL), {4'h0, MODE_RISE16});
      wr(OFS_FLAG, 8'h03);
      repeat (13) i_src.pulse(0);
      fchk(2'h0);
      i_src.pulse(0);
      fchk(2'h1);
   endtask
   task automatic t_sleep();
      logic [31:0] a, b;
      set_timer(16'h0000);
      wr(OFS_TIMER_CTRL, 8'h01);
      @(posedge i_clock) i_sleep <= 1'b1;
      bus(1'b0, OFS_TIMER_LOW, 32'h0, a);
      repeat (20) @(posedge i_clock);
      rdc("sleep hold", OFS_TIMER_LOW, a);
      @(posedge i_clock) i_sleep <= 1'b0;
      repeat (20) @(posedge i_clock);
      bus(1'b0, OFS_TIMER_LOW, 32'h0, b);
      chk("resume", 32'h1, {31'h0, (b > a) && (b < a + 32'd12)});
      wr(OFS_TIMER_CTRL, 8'h00);
      prep(0, MODE_RISE, 16'h01f0);
      @(posedge i_clock) i_sleep <= 1'b1;
      wr(OFS_TIMER_CTRL, 8'h03);
      i_src.ticks(20);
      i_src.pulse(0);
      fchk(2'h1);
      res(0, 16'h0204);
      wr(OFS_TIMER_CTRL, 8'h00);
      @(posedge i_clock) i_sleep <= 1'b0;
   endtask
   // clock enable low: a pin pulse must not be seen at all
   task automatic t_freeze();
      prep(0, MODE_RISE, 16'h0abc);
      @(posedge i_clock) i_clk_en <= 1'b0;
      i_src.pulse(0);
      fchk(2'h0);
      @(posedge i_clock) i_clk_en <= 1'b1;
      repeat (4) @(posedge i_clock);
      fchk(2'h0);
      i_src.pulse(0);
      fchk(2'h1);
      res(0, 16'h0abc);
   endtask
   // reset in mid-count, then a fresh divide-by-4 from zero
   task automatic t_reset_mid();
      prep(0, MODE_RISE4, 16'h0abc);
      repeat (3) i_src.pulse(0);
      @(posedge i_clock) i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      fchk(2'h0);
      rdc("mode after reset", ua(0, OFS_UNIT_CTRL), 32'h0);
      wr(ua(0, OFS_UNIT_CTRL), {4'h0, MODE_RISE4});
      repeat (3) i_src.pulse(0);
      fchk(2'h0);
      i_src.pulse(0);
      fchk(2'h1);
      wr(OFS_FLAG, 8'h03);
      wr(ua(0, OFS_UNIT_CTRL), 8'h0c);
      i_src.pulse(0);
      fchk(2'h0);
   endtask
   initial begin
      i_clock = 1'b0;
      i_rst_n = 1'b0;
      i_clk_en = 1'b1;
      i_address = 8'h00;
      i_read = 1'b0;
      i_write = 1'b0;
      i_writedata = 32'h0;
      i_byteenable = 4'hf;
      i_sleep = 1'b0;
      failures = 0;
      compares = 0;
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b1;
      t_reset();
      t_modes();
      t_overwrite();
      t_out_pin();
      t_presc();
      t_sleep();
      t_freeze();
      t_reset_mid();
      wrap_up();
   end
endmodule // timer_capture_unit_bench
`default_nettype wire
